// ---- eeprom_pkg.sv ----
// shared constants and types for the serial eeprom command and write-control block
package eeprom_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int PAGE_BYTES = 16;
    localparam int PAGE_BITS = 4;
    // instruction codes, bit 3 is ignored on decode
    localparam logic [7:0] CMD_MASK = 8'hf7;
    localparam logic [7:0] CMD_ARRAY_READ = 8'h03;
    localparam logic [7:0] CMD_ARRAY_WRITE = 8'h02;
    localparam logic [7:0] CMD_LATCH_CLEAR = 8'h04;
    localparam logic [7:0] CMD_LATCH_SET = 8'h06;
    localparam logic [7:0] CMD_STATUS_READ = 8'h05;
    localparam logic [7:0] CMD_STATUS_WRITE = 8'h01;
    // status byte field positions
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_LATCH_BIT = 1;
    localparam int ST_PROT_LO_BIT = 2;
    localparam int ST_PROT_HI_BIT = 3;
    // block-protect value after reset (nonvolatile model, factory setting)
    localparam logic [1:0] PROT_RESET = 2'b01;
    localparam logic [7:0] PROT_QUARTER_BASE = 8'hc0;
    localparam logic [7:0] PROT_HALF_BASE = 8'h80;
    // self-timed write cycle
    localparam longint WRITE_TIME_NS = 5000000;
    localparam longint CLK_PERIOD_NS = 25;
    localparam int WRITE_CYCLES = int'(WRITE_TIME_NS / CLK_PERIOD_NS);
    localparam int BIT_CNT_RESET = 0;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_CMD = 3'b001,
        ST_ADDR = 3'b010,
        ST_DATA = 3'b011,
        ST_STATUS_OUT = 3'b100,
        ST_STATUS_IN = 3'b101,
        ST_IGNORE = 3'b110
    } frame_state_t;

    // one buffered page byte: its in-page slot and its value
    typedef struct packed {
        logic [PAGE_BITS-1:0] slot;
        logic [DATA_W-1:0] data;
    } page_word_t;
endpackage : eeprom_pkg

// ---- page_fifo.sv ----
// parameterised fifo holding page-write bytes until the array takes them
`timescale 1ns/1ps
`default_nettype none
module page_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 32
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0] wr_q;
    logic [AW:0] rd_q;
    logic [AW:0] cnt;

    assign cnt = wr_q - rd_q;
    assign in_ready = (cnt != (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
    assign out_valid = (cnt != '0);

    // write side
    always_ff @(posedge clk_sys) begin
        if (srst || flush) begin
            wr_q <= '0;
        end else if (in_valid && in_ready) begin
            mem_q[wr_q[AW-1:0]] <= in_data;
            wr_q <= wr_q + 1'b1;
        end
    end

    // read side; data comes out of a register
    always_ff @(posedge clk_sys) begin
        if (srst || flush) begin
            rd_q <= '0;
        end else if (out_valid && out_ready) begin
            rd_q <= rd_q + 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            out_data <= '0;
        end else begin
            out_data <= mem_q[(out_valid && out_ready) ? rd_q[AW-1:0] + 1'b1 : rd_q[AW-1:0]];
        end
    end
endmodule : page_fifo
`default_nettype wire

// ---- eeprom_write_ctrl.sv ----
// command decode, write enable latch, page buffering and protection of the serial eeprom
// What this block does
// - latch sets only on chip-select rise after a complete eight-bit latch-set byte.
// - write following latch-set in same frame finds latch clear and is not written.
// - write frame is command, address, data bytes; up to 32 bytes buffered.
// - write address wraps within its 16-byte page, later bytes up to the 32nd overwrite earlier.
// - write cycle starts only if chip select rises right after a byte's last bit.
// - array access during internal write is ignored; programming continues.
// - latch cleared at reset, latch-clear, completed writes, and while guard pin low.
// - read decodes 0000x011, write 0000x010, bit 3 ignored.
// - latch-set 0000x110 sets, latch-clear 0000x100 clears, bit 3 ignored.
// - status read works any time incl. during write; status write stores it.
// - status bit 0 read-only busy flag, 1 while internal write runs.
// - status bit 1 read-only mirror of latch; latch commands update it only while guard pin high.
// - protect select bits 3 and 2 written by status write; bits 7..4 don't-care.
// - protect field 00 none, 01 C0-FF, 10 80-FF, 11 whole array.
// - writes need latch set and guard pin high; protected blocks stay protected.
// - after reset idle, latch clear, output off; a chip select held low through reset starts a frame.
// - top quarter holds node address, guarded by block-protect setting.
// - bits travel msb first, sampled on rising serial clock.
// - array instructions are followed by one eight-bit address byte.
// - internal write cycle ends within 5 ms of its start.
`timescale 1ns/1ps
`default_nettype none
module eeprom_write_ctrl
    import eeprom_pkg::*;
#(
    parameter int WRITE_CYCLES_P = WRITE_CYCLES,
    parameter int FIFO_DEPTH = 32
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic sel_n,
    input wire logic sclk,
    input wire logic sdi,
    output logic sdo,
    output logic sdo_oe,
    input wire logic write_guard_pin,
    output logic arr_we,
    output logic [ADDR_W-1:0] arr_addr,
    output logic [DATA_W-1:0] arr_wdata,
    output logic [ADDR_W-1:0] arr_raddr,
    output logic arr_rd,
    output logic [7:0] status_byte
);
    // two-flop synchronisers for the pins
    logic [1:0] sel_meta_q, sclk_meta_q, sdi_meta_q, guard_meta_q;
    logic sel_s_q, sclk_s_q, sdi_s_q, guard_s_q;
    logic sel_prev_q, sclk_prev_q;
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            sel_meta_q <= 2'b11;
            sclk_meta_q <= 2'b00;
            sdi_meta_q <= 2'b00;
            guard_meta_q <= 2'b00;
        end else begin
            sel_meta_q <= {sel_meta_q[0], sel_n};
            sclk_meta_q <= {sclk_meta_q[0], sclk};
            sdi_meta_q <= {sdi_meta_q[0], sdi};
            guard_meta_q <= {guard_meta_q[0], write_guard_pin};
        end
    end
    assign sel_s_q = sel_meta_q[1];
    assign sclk_s_q = sclk_meta_q[1];
    assign sdi_s_q = sdi_meta_q[1];
    assign guard_s_q = guard_meta_q[1];

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            sel_prev_q <= 1'b1;
            sclk_prev_q <= 1'b0;
        end else begin
            sel_prev_q <= sel_s_q;
            sclk_prev_q <= sclk_s_q;
        end
    end

    logic frame_start, frame_end, sclk_rise, sclk_fall, selected;
    assign frame_start = sel_prev_q && !sel_s_q;
    assign frame_end = !sel_prev_q && sel_s_q;
    assign selected = !sel_s_q && !sel_prev_q;
    assign sclk_rise = selected && !sclk_prev_q && sclk_s_q;
    assign sclk_fall = selected && sclk_prev_q && !sclk_s_q;

    // frame state and bit shifting
    frame_state_t state_q;
    logic [2:0] bit_q;
    logic [7:0] shift_q;
    logic [7:0] cmd_q;
    logic [7:0] addr_q;
    logic [7:0] shift_nx;
    logic byte_done;
    logic busy_q;
    logic latch_q;
    logic [1:0] prot_q;
    logic [7:0] status_wr_q;
    logic byte_aligned_q;    // last bit taken closed a byte
    logic got_data_q;
    logic cmd_match_set, cmd_match_clr, cmd_is_write, cmd_is_sread, cmd_is_swrite, cmd_is_read;

    assign shift_nx = {shift_q[6:0], sdi_s_q};
    assign byte_done = sclk_rise && (bit_q == 3'd7);

    // decode with bit 3 masked out
    assign cmd_match_set = ((shift_nx & CMD_MASK) == CMD_LATCH_SET);
    assign cmd_match_clr = ((shift_nx & CMD_MASK) == CMD_LATCH_CLEAR);
    assign cmd_is_write = ((shift_nx & CMD_MASK) == CMD_ARRAY_WRITE);
    assign cmd_is_read = ((shift_nx & CMD_MASK) == CMD_ARRAY_READ);
    assign cmd_is_sread = ((shift_nx & CMD_MASK) == CMD_STATUS_READ);
    assign cmd_is_swrite = ((shift_nx & CMD_MASK) == CMD_STATUS_WRITE);

    always_ff @(posedge clk_sys) begin
        if (srst || frame_start) begin
            bit_q <= 3'd0;
            shift_q <= 8'h00;
        end else if (sclk_rise) begin
            bit_q <= bit_q + 3'd1;
            shift_q <= shift_nx;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst || frame_start) begin
            byte_aligned_q <= 1'b0;
        end else if (sclk_rise) begin
            byte_aligned_q <= (bit_q == 3'd7);
        end
    end

    // frame sequencing; the command byte is held for the frame's end
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state_q <= ST_IDLE;
            cmd_q <= 8'h00;
            addr_q <= 8'h00;
            got_data_q <= 1'b0;
            status_wr_q <= 8'h00;
        end else if (frame_start) begin
            state_q <= ST_CMD;
            cmd_q <= 8'h00;
            got_data_q <= 1'b0;
        end else if (frame_end) begin
            state_q <= ST_IDLE;
        end else if (byte_done) begin
            case (state_q)
                ST_CMD: begin
                    cmd_q <= shift_nx;
                    if (cmd_is_write || cmd_is_read) begin
                        state_q <= ST_ADDR;
                    end else if (cmd_is_sread) begin
                        state_q <= ST_STATUS_OUT;
                    end else if (cmd_is_swrite) begin
                        state_q <= ST_STATUS_IN;
                    end else begin
                        state_q <= ST_IGNORE;
                    end
                end
                ST_ADDR: begin
                    addr_q <= shift_nx;
                    state_q <= ((cmd_q & CMD_MASK) == CMD_ARRAY_WRITE) ? ST_DATA : ST_IGNORE;
                end
                ST_DATA: begin
                    got_data_q <= 1'b1;
                    addr_q <= {addr_q[7:4], addr_q[3:0] + 4'd1};
                end
                ST_STATUS_IN: begin
                    status_wr_q <= shift_nx;
                    got_data_q <= 1'b1;
                end
                default: begin
                    got_data_q <= 1'b1;              // a further byte rules out a lone command
                end
            endcase
        end
    end

    // protection: latch, guard pin and block-protect field all gate a write
    function automatic logic addr_protected(input logic [1:0] prot, input logic [7:0] a);
        case (prot)
            2'b00: addr_protected = 1'b0;
            2'b01: addr_protected = (a >= PROT_QUARTER_BASE);
            2'b10: addr_protected = (a >= PROT_HALF_BASE);
            default: addr_protected = 1'b1;
        endcase
    endfunction : addr_protected

    logic write_ok;
    logic push_valid, push_ready;
    page_word_t push_word, pop_word;
    logic pop_valid, pop_ready;
    logic fifo_flush;

    assign write_ok = latch_q && guard_s_q && !busy_q;
    assign push_word = '{slot: addr_q[3:0], data: shift_nx};
    // the buffer holds unprotected bytes only, so a protected target simply drops out
    assign push_valid = (state_q == ST_DATA) && byte_done && write_ok
                        && !addr_protected(prot_q, addr_q);
    // the buffer is twice a page deep, so frame bytes are refused only past the 32nd
    logic commit_q;
    logic [ADDR_W-PAGE_BITS-1:0] page_q;
    logic commit_ok, cmd_q_write, cmd_q_swrite;
    assign cmd_q_write = ((cmd_q & CMD_MASK) == CMD_ARRAY_WRITE);
    assign cmd_q_swrite = ((cmd_q & CMD_MASK) == CMD_STATUS_WRITE);
    assign commit_ok = byte_aligned_q && got_data_q && write_ok
                       && (cmd_q_write || cmd_q_swrite);
    // no flush while busy, so status polls cannot cut the drain of a committed page
    assign fifo_flush = !busy_q && (frame_start || (frame_end && !commit_ok));
    page_fifo #(
        .WIDTH($bits(page_word_t)),
        .DEPTH(FIFO_DEPTH)
    ) page_fifo_i (
        .clk_sys(clk_sys),
        .srst(srst),
        .flush(fifo_flush),
        .in_valid(push_valid),
        .in_ready(push_ready),
        .in_data(push_word),
        .out_valid(pop_valid),
        .out_ready(pop_ready),
        .out_data(pop_word)
    );

    // self-timed write cycle: drain buffer into array, then time out
    logic [$clog2(WRITE_CYCLES_P+1)-1:0] wcnt_q;
    logic pop_pend_q, busy_done;
    assign busy_done = busy_q
                       && (wcnt_q == ($clog2(WRITE_CYCLES_P+1))'(WRITE_CYCLES_P - 1));
    assign pop_ready = busy_q && commit_q && !pop_pend_q;
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            busy_q <= 1'b0;
            commit_q <= 1'b0;
            wcnt_q <= '0;
            page_q <= '0;
            pop_pend_q <= 1'b0;
        end else if (!busy_q) begin
            if (frame_end && commit_ok) begin
                busy_q <= 1'b1;
                commit_q <= cmd_q_write;
                page_q <= addr_q[7:4];
                wcnt_q <= '0;
            end
        end else begin
            pop_pend_q <= pop_valid && pop_ready;   // every other cycle, output reg reloads
            if (busy_done) begin
                busy_q <= 1'b0;
                commit_q <= 1'b0;
            end else begin
                wcnt_q <= wcnt_q + 1'b1;
            end
        end
    end

    // array write port, registered
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            arr_we <= 1'b0;
            arr_addr <= 8'h00;
            arr_wdata <= 8'h00;
        end else begin
            arr_we <= pop_valid && pop_ready;       // popped word stands on the fifo output
            arr_addr <= {page_q, pop_word.slot};
            arr_wdata <= pop_word.data;
        end
    end

    // block-protect bits; a status write lands at the frame end
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            prot_q <= PROT_RESET;
        end else if (frame_end && commit_ok && cmd_q_swrite) begin
            prot_q <= {status_wr_q[ST_PROT_HI_BIT], status_wr_q[ST_PROT_LO_BIT]};
        end
    end

    // write enable latch; guard pin low wins over everything
    logic cmd_byte_only;
    assign cmd_byte_only = (state_q == ST_IGNORE) && byte_aligned_q && !got_data_q;
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            latch_q <= 1'b0;
        end else if (!guard_s_q) begin
            latch_q <= 1'b0;
        end else if (busy_done) begin
            latch_q <= 1'b0;
        end else if (frame_end && cmd_byte_only
                     && (cmd_q & CMD_MASK) == CMD_LATCH_CLEAR) begin
            latch_q <= 1'b0;
        end else if (frame_end && cmd_byte_only
                     && (cmd_q & CMD_MASK) == CMD_LATCH_SET) begin
            latch_q <= 1'b1;
        end
    end

    // status byte view; upper bits read as zero
    always_comb begin
        status_byte = 8'h00;
        status_byte[ST_BUSY_BIT] = busy_q;
        status_byte[ST_LATCH_BIT] = latch_q;
        status_byte[ST_PROT_LO_BIT] = prot_q[0];
        status_byte[ST_PROT_HI_BIT] = prot_q[1];
    end

    // serial output: status shifted out msb first after falling clock
    logic [7:0] out_shift_q;
    always_ff @(posedge clk_sys) begin
        if (srst || !selected) begin
            out_shift_q <= 8'h00;
            sdo <= 1'b0;
            sdo_oe <= 1'b0;
        end else if (state_q == ST_STATUS_OUT && sclk_fall) begin
            sdo_oe <= 1'b1;
            sdo <= (bit_q == 3'd0) ? status_byte[7] : out_shift_q[7];
            out_shift_q <= (bit_q == 3'd0) ? {status_byte[6:0], 1'b0}
                                           : {out_shift_q[6:0], 1'b0};
        end
    end

    // array read requests are refused while a write cycle runs
    logic rd_req;
    assign rd_req = (state_q == ST_ADDR) && byte_done && !busy_q
                    && ((cmd_q & CMD_MASK) == CMD_ARRAY_READ);
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            arr_rd <= 1'b0;
            arr_raddr <= 8'h00;
        end else begin
            arr_rd <= rd_req;
            arr_raddr <= rd_req ? shift_nx : arr_raddr;   // held until the next request
        end
    end
endmodule : eeprom_write_ctrl
`default_nettype wire

// ---- eeprom_write_ctrl_asserts.sv ----
// port-level assertion checker for the eeprom write-control block
`timescale 1ns/1ps
`default_nettype none
module eeprom_write_ctrl_asserts
    import eeprom_pkg::*;
#(
    parameter int WRITE_CYCLES_P = WRITE_CYCLES
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic sel_n,
    input wire logic sclk,
    input wire logic sdi,
    input wire logic sdo,
    input wire logic sdo_oe,
    input wire logic write_guard_pin,
    input wire logic arr_we,
    input wire logic [ADDR_W-1:0] arr_addr,
    input wire logic [DATA_W-1:0] arr_wdata,
    input wire logic [ADDR_W-1:0] arr_raddr,
    input wire logic arr_rd,
    input wire logic [7:0] status_byte
);
    int busy_cnt_q;
    // length of the running busy period, a repetition would be far too long
    always_ff @(posedge clk_sys) begin
        if (srst || !status_byte[ST_BUSY_BIT]) busy_cnt_q <= 0;
        else busy_cnt_q <= busy_cnt_q + 1;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);
    AST_RD_NOT_BUSY: assert property (arr_rd |-> !status_byte[0])
        else $error("array read issued during write cycle");
    AST_WE_IN_BUSY: assert property (arr_we |-> status_byte[0])
        else $error("array write outside write cycle");
    AST_WE_UNPROT: assert property (arr_we |-> (status_byte[3:2] == 2'b00)
        || (status_byte[3:2] == 2'b01 && arr_addr < 8'hc0)
        || (status_byte[3:2] == 2'b10 && arr_addr < 8'h80))
        else $error("write into protected block");
    AST_GUARD_CLR: assert property (!write_guard_pin [*4] |=> !status_byte[1])
        else $error("latch set while guard pin low");
    AST_BUSY_DESEL: assert property ($rose(status_byte[0]) |-> sel_n && $past(sel_n, 2))
        else $error("write cycle began while selected");
    AST_LATCH_DESEL: assert property ($rose(status_byte[1]) |-> sel_n)
        else $error("latch set inside a frame");
    AST_LATCH_END: assert property ($fell(status_byte[0]) |-> !status_byte[1])
        else $error("latch still set after write cycle");
    AST_BUSY_BOUND: assert property (busy_cnt_q <= WRITE_CYCLES_P)
        else $error("write cycle too long");
    AST_UPPER_ZERO: assert property (status_byte[7:4] == 4'h0)
        else $error("status upper bits not zero");
    AST_SDO_OFF: assert property (sel_n [*4] |-> !sdo_oe)
        else $error("serial out driven while deselected");
endmodule : eeprom_write_ctrl_asserts
bind eeprom_write_ctrl eeprom_write_ctrl_asserts #(.WRITE_CYCLES_P(WRITE_CYCLES_P))
    eeprom_write_ctrl_asserts_i (.clk_sys(clk_sys), .srst(srst), .sel_n(sel_n), .sclk(sclk),
    .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .write_guard_pin(write_guard_pin),
    .arr_we(arr_we), .arr_addr(arr_addr), .arr_wdata(arr_wdata), .arr_raddr(arr_raddr),
    .arr_rd(arr_rd), .status_byte(status_byte));
`default_nettype wire

// ---- spi_host_model.sv ----
// spi host model driving the eeprom pins, clock parked low
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
    input wire logic clk_sys,
    input wire logic sdo,
    input wire logic sdo_oe,
    output logic sel_n,
    output logic sclk,
    output logic sdi
);
    // idle: deselected, no clock
    initial begin
        sel_n = 1'b1;
        sclk = 1'b0;
        sdi = 1'b0;
    end
    // one frame, bits taken from the top of d; cut short frames come from nbits
    task automatic frame(input logic [143:0] d, input int nbits, output logic [7:0] rx);
        rx = 8'h00;
        @(posedge clk_sys);
        sel_n <= 1'b0;
        repeat (5) @(posedge clk_sys);
        for (int i = 0; i < nbits; i++) begin
            sdi <= d[143-i];
            repeat (4) @(posedge clk_sys);
            sclk <= 1'b1;
            rx = {rx[6:0], sdo_oe ? sdo : 1'b0};
            repeat (4) @(posedge clk_sys);
            sclk <= 1'b0;
        end
        repeat (4) @(posedge clk_sys);
        sel_n <= 1'b1;
        sdi <= ~sdi; // released line must not look held
        repeat (8) @(posedge clk_sys);
    endtask : frame
endmodule : spi_host_model
`default_nettype wire

// ---- eeprom_write_ctrl_tb.sv ----
// self-checking bench for the eeprom write-control block
`timescale 1ns/1ps
`default_nettype none
module eeprom_write_ctrl_tb
    import eeprom_pkg::*;
;
    logic clk_sys, srst, write_guard_pin, sel_n, sclk, sdi, sdo, sdo_oe, arr_we, arr_rd;
    logic [ADDR_W-1:0] arr_addr, arr_raddr;
    logic [DATA_W-1:0] arr_wdata;
    logic [7:0] status_byte, rx, a, old;
    logic [7:0] mem [0:255];
    int failures, n_compared, n_we, n_rd;
    bit prot;
    eeprom_write_ctrl #(.WRITE_CYCLES_P(400)) eeprom_write_ctrl_i (.clk_sys(clk_sys),
        .srst(srst), .sel_n(sel_n), .sclk(sclk), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe),
        .write_guard_pin(write_guard_pin), .arr_we(arr_we), .arr_addr(arr_addr),
        .arr_wdata(arr_wdata), .arr_raddr(arr_raddr), .arr_rd(arr_rd),
        .status_byte(status_byte));
    spi_host_model spi_host_model_i (.clk_sys(clk_sys), .sdo(sdo), .sdo_oe(sdo_oe),
        .sel_n(sel_n), .sclk(sclk), .sdi(sdi));
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    // array model fed by the write strobes
    always @(posedge clk_sys) begin
        if (arr_we) begin
            mem[arr_addr] <= arr_wdata;
            n_we <= n_we + 1;
        end
        if (arr_rd) n_rd <= n_rd + 1;
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic stop_test();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : stop_test
    task automatic xfer(input logic [143:0] d, input int nbits);
        spi_host_model_i.frame(d, nbits, rx);
    endtask : xfer
    // poll status until the write cycle ends, bounded
    task automatic wait_idle();
        for (int i = 0; i < 40; i++) begin
            xfer({8'h05, 136'h0}, 16);
            if (rx[0] === 1'b0) return;
        end
        failures++;
        stop_test();
    endtask : wait_idle
    task automatic wr(input logic [7:0] ad, input logic [7:0] v);
        xfer({8'h06, 136'h0}, 8);
        xfer({8'h02, ad, v, 120'h0}, 24);
        wait_idle();
    endtask : wr
    // hang guard
    initial begin
        repeat (100000) @(posedge clk_sys);
        failures++;
        stop_test();
    end
    initial begin
        srst = 1'b1;
        write_guard_pin = 1'b1;
        failures = 0;
        n_compared = 0;
        n_we = 0;
        n_rd = 0;
        for (int i = 0; i < 256; i++) mem[i] = 8'h00;
        repeat (16) @(posedge clk_sys);
        srst <= 1'b0;
        repeat (4) @(posedge clk_sys);
        chk(status_byte, 8'h04);
        chk({7'h0, sdo_oe}, 8'h00);
        for (int i = 0; i < 2; i++) begin
            xfer({8'h06 | 8'(i * 8), 136'h0}, 8);
            chk(status_byte, 8'h06);
            xfer({8'h04 | 8'(i * 8), 136'h0}, 8);
            chk(status_byte, 8'h04);
        end
        xfer({8'h06, 136'h0}, 9);
        chk(status_byte, 8'h04);
        xfer({8'h06, 8'h02, 8'h10, 8'hab, 112'h0}, 32);
        wait_idle();
        chk(mem[8'h10], 8'h00);
        chk(status_byte, 8'h04);
        $display("test latch done");
        xfer({8'h06, 136'h0}, 8);
        xfer({8'h02, 8'h10, 8'hab, 120'h0}, 24);
        xfer({8'h05, 136'h0}, 16);
        chk(rx, 8'h07);
        xfer({8'h03, 8'h20, 128'h0}, 16);
        chk(8'(n_rd), 8'h00);
        wait_idle();
        chk(mem[8'h10], 8'hab);
        chk(status_byte, 8'h04);
        xfer({8'h0b, 8'h20, 128'h0}, 16);
        chk(8'(n_rd), 8'h01);
        chk(arr_raddr, 8'h20);
        xfer({8'h06, 136'h0}, 8);
        xfer({8'h0a, 8'h3e, 32'h11223344, 96'h0}, 48);
        wait_idle();
        chk(mem[8'h3e], 8'h11);
        chk(mem[8'h30], 8'h33);
        chk(mem[8'h31], 8'h44);
        chk(mem[8'h40], 8'h00);
        chk(8'(n_we), 8'h05);
        $display("test write done");
        xfer({8'h06, 136'h0}, 8);
        xfer({8'h02, 8'h50, 8'h66, 120'h0}, 20);
        xfer({8'h01, 8'h0c, 128'h0}, 12);
        chk(status_byte, 8'h06);
        chk(mem[8'h50], 8'h00);
        xfer({8'h04, 136'h0}, 8);
        $display("test abort done");
        for (int p = 3; p >= 0; p--) begin
            xfer({8'h06, 136'h0}, 8);
            xfer({8'h01, 8'hf0 | 8'(p * 4), 128'h0}, 16);
            wait_idle();
            chk(status_byte, 8'(p * 4));
            for (int b = 0; b < 3; b++) begin
                a = (b == 0) ? 8'h07 : (b == 1) ? 8'h87 : 8'hc7;
                prot = (p == 3) || (p == 2 && a >= 8'h80) || (p == 1 && a >= 8'hc0);
                old = mem[a];
                wr(a, 8'h50 + 8'(p));
                chk(mem[a], prot ? old : 8'h50 + 8'(p));
            end
        end
        $display("test protect done");
        xfer({8'h06, 136'h0}, 8);
        @(posedge clk_sys);
        write_guard_pin <= 1'b0;
        repeat (6) @(posedge clk_sys);
        chk(status_byte, 8'h00);
        old = mem[8'h07];
        wr(8'h07, 8'he1);
        xfer({8'h06, 136'h0}, 8);
        xfer({8'h01, 8'h0c, 128'h0}, 16);
        repeat (20) @(posedge clk_sys);
        chk(mem[8'h07], old);
        chk(status_byte, 8'h00);
        write_guard_pin <= 1'b1;
        $display("test guard done");
        stop_test();
    end
endmodule : eeprom_write_ctrl_tb
`default_nettype wire
